/* tb_trace_capture_output.sv */
// Purpose: Drives the core side and reads the pod side of the trace link.
// Assumes: Both ends share one clock; the link joins them directly.
// Notes: Records are compared in the order the emulator strobes them.
`timescale 1ns/10ps
module tb_trace_capture_output;
	import trace_pkg::*;
	localparam int DIV_HALF = 4;
	localparam logic [31:0] SRCS [4] = '{32'h0000_1008, 32'h0000_10F0,
		32'h0000_A0F0, 32'h0100_A0F0};
	logic             clk, rst_n, user_break_controller, rt, br_en, hist_en, sw_en;
	logic [2:0]       type_en, hist_idx;
	logic [1:0]       win_en, addr;
	rw_sel_e          win_rw [2];
	bus_sel_e         win_bus [2];
	logic [31:0]      win_start [2], win_end [2];
	logic             br_valid, exc, cond, zd, rreset, sw_valid, wr, rd;
	br_kind_e         br_kind;
	logic [31:0]      src, dst, nxt, sw_pc, sw_reg, wdata, rdata;
	logic [31:0]      hsrc, hdst, rec_addr, rec_extra;
	logic [3:0]       acc_valid, acc_wr, acc_hit, acc_dma;
	logic [3:0][31:0] acc_addr;
	logic             stall, drop, rec_valid, rec_full;
	kind_e            rec_kind;
	int               num_errors, tests_run, nrec, n;

	trace_link_if link();
	trace_device #(.DIV_HALF(DIV_HALF)) i_trace_device (
		.i_clock(clk), .i_rst_n(rst_n), .i_ubc_user(user_break_controller),
		.i_realtime(rt), .i_br_trace_en(br_en), .i_br_type_en(type_en),
		.i_hist_en(hist_en), .i_sw_en(sw_en), .i_win_en(win_en),
		.i_win_rw(win_rw), .i_win_bus(win_bus), .i_win_start(win_start),
		.i_win_end(win_end), .i_br_valid(br_valid), .i_br_kind(br_kind),
		.i_br_src(src), .i_br_dst(dst), .i_br_next_pc(nxt),
		.i_br_exc_done(exc), .i_br_cond(cond), .i_br_zero_disp(zd),
		.i_br_reset(rreset), .i_acc_valid(acc_valid), .i_acc_addr(acc_addr),
		.i_acc_wr(acc_wr), .i_acc_hit(acc_hit), .i_acc_dma(acc_dma),
		.i_sw_valid(sw_valid), .i_sw_pc(sw_pc), .i_sw_reg(sw_reg),
		.i_hist_idx(hist_idx), .o_hist_src(hsrc), .o_hist_dst(hdst),
		.o_stall(stall), .o_drop(drop), .link(link));
	trace_emulator i_trace_emulator (
		.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rec_valid(rec_valid),
		.o_rec_kind(rec_kind), .o_rec_addr(rec_addr),
		.o_rec_extra(rec_extra), .o_rec_full(rec_full), .link(link));
	trace_link_checker #(.DIV_HALF(DIV_HALF)) i_trace_link_checker (
		.i_clock(clk), .i_rst_n(rst_n),
		.trace_port_clock(link.trace_port_clock),
		.trace_output_port(link.trace_output_port),
		.trace_sync(link.trace_sync));

	task automatic results;
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic br(input br_kind_e k, input logic [31:0] s,
		input logic [31:0] d, input logic [3:0] f);
		@(posedge clk);
		br_valid <= 1'b1;
		br_kind <= k;
		src <= s;
		dst <= d;
		nxt <= s + 32'h0000_0002;
		{exc, cond, zd, rreset} <= f;
		@(posedge clk);
		br_valid <= 1'b0;
	endtask

	task automatic sw(input logic [31:0] p, input logic [31:0] r);
		@(posedge clk);
		sw_valid <= 1'b1;
		sw_pc <= p;
		sw_reg <= r;
		@(posedge clk);
		sw_valid <= 1'b0;
	endtask

	// Flags are {write, cache hit, dma}.
	task automatic acc(input int b, input logic [31:0] a,
		input logic [2:0] f);
		@(posedge clk);
		acc_valid <= 4'(1 << b);
		acc_addr[b] <= a;
		{acc_wr[b], acc_hit[b], acc_dma[b]} <= f;
		@(posedge clk);
		acc_valid <= 4'h0;
	endtask

	// The extra edge at the end keeps a later call off the same strobe.
	task automatic exp_rec(input kind_e k, input logic [31:0] a,
		input logic [31:0] x, input logic f);
		int w;
		w = 0;
		while (rec_valid !== 1'b1 && w < 800) begin
			@(posedge clk);
			#1;
			w++;
		end
		nrec++;
		chk(32'(rec_kind), 32'(k));
		chk(rec_addr, a);
		chk(rec_extra, x);
		chk(32'(rec_full), 32'(f));
		@(posedge clk);
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [1:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic hist(input logic [2:0] i, input logic [31:0] s,
		input logic [31:0] d);
		@(posedge clk);
		hist_idx <= i;
		@(posedge clk);
		#1;
		chk(hsrc, s);
		chk(hdst, d);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		{user_break_controller, br_valid, exc, cond, zd, rreset, sw_valid, wr, rd} = '0;
		{rt, br_en, hist_en, sw_en} = 4'hF;
		{type_en, hist_idx, win_en, addr} = 10'h38C;
		{src, dst, nxt, sw_pc, sw_reg, wdata} = '0;
		{acc_valid, acc_wr, acc_hit, acc_dma} = '0;
		acc_addr = '0;
		br_kind = BR_NORMAL;
		win_rw = '{RW_READ, RW_BOTH};
		win_bus = '{BUS_L, BUS_I};
		win_start = '{32'h0000_0100, 32'h0000_0300};
		win_end = '{32'h0000_01FF, 32'h0000_03FF};
		{num_errors, tests_run, nrec, n} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		sw(32'h1234_5678, 32'h0BAD_F00D);
		exp_rec(K_SOFT, 32'h1234_5678, 32'h0BAD_F00D, 1'b1);
		br(BR_NORMAL, 32'h0000_1000, 32'h0000_2000, 4'h0);
		exp_rec(K_BRANCH, 32'h0000_1000, 32'h0000_2000, 1'b1);
		for (int i = 0; i < 4; i++) begin
			br(BR_NORMAL, SRCS[i], SRCS[i] + 32'h0000_0100, 4'h0);
			exp_rec(K_BRANCH, SRCS[i], SRCS[i] + 32'h100, 1'b1);
		end
		br(BR_NORMAL, 32'h0100_A0F2, 32'h0000_0000, 4'b0110);
		br(BR_NORMAL, 32'h0100_A0F3, 32'hA000_0000, 4'b0001);
		br(BR_SUB, 32'h0100_A0F4, 32'h0000_0300, 4'h0);
		exp_rec(K_BRANCH, 32'h0100_A0F4, 32'h0000_0300, 1'b1);
		br(BR_EXC, 32'h0100_A100, 32'h0000_0400, 4'b1000);
		exp_rec(K_BRANCH, 32'h0100_A102, 32'h0000_0400, 1'b1);
		// History runs with the port quiet so no records pile up.
		br_en <= 1'b0;
		for (int i = 0; i < 9; i++)
			br(BR_NORMAL, 32'h2000 + 32'(i) * 32'h10, 32'h5000 + 32'(i), 4'h0);
		for (int i = 0; i < 8; i++)
			hist(3'(i), 32'h2080 - 32'(i) * 32'h10, 32'h5008 - 32'(i));
		@(posedge clk);
		{user_break_controller, br_en} <= 2'b11;
		br(BR_NORMAL, 32'h0000_7000, 32'h0000_7100, 4'h0);
		sw(32'h1234_5680, 32'h0000_0001);
		hist(3'h0, 32'h0000_2080, 32'h0000_5008);
		@(posedge clk);
		user_break_controller <= 1'b0;
		sw(32'h1234_5690, 32'h0000_0002);
		exp_rec(K_SOFT, 32'h1234_5690, 32'h0000_0002, 1'b1);
		br(BR_NORMAL, 32'h0100_A200, 32'h0000_0010, 4'h0);
		exp_rec(K_BRANCH, 32'h0100_A200, 32'h0000_0010, 1'b1);
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			win_rw[0] <= rw_sel_e'(m);
			acc(0, 32'h0000_0100, 3'b010);
			if (m != 1) exp_rec(K_WIN_A, 32'h100, 32'h0, 1'b1);
			acc(0, 32'h0000_01FF, 3'b100);
			if (m != 0) exp_rec(K_WIN_A, 32'h1FF, 32'h0, 1'b1);
		end
		acc(0, 32'h0000_0200, 3'b000);
		acc(0, 32'h0000_00FF, 3'b000);
		acc(0, 32'h0000_0150, 3'b001);
		acc(0, 32'h0000_0180, 3'b000);
		exp_rec(K_WIN_A, 32'h0000_0180, 32'h0, 1'b1);
		acc(3, 32'hF000_0310, 3'b001);
		exp_rec(K_WIN_B, 32'h0000_0310, 32'h0, 1'b1);
		acc(3, 32'h0000_0320, 3'b010);
		acc(3, 32'h0000_0330, 3'b100);
		exp_rec(K_WIN_B, 32'h0000_0330, 32'h0, 1'b1);
		@(posedge clk);
		win_en <= 2'b01;
		acc(3, 32'h0000_0340, 3'b000);
		@(posedge clk);
		win_en <= 2'b11;
		acc(3, 32'h0000_0350, 3'b000);
		exp_rec(K_WIN_B, 32'h0000_0350, 32'h0, 1'b1);
		wr_reg(2'h0, 32'h0000_0001);
		rd_reg(2'h0, 32'h0000_0000);
		acc(0, 32'h0000_0185, 3'b000);
		exp_rec(K_WIN_A, 32'h0000_0005, 32'h0, 1'b0);
		rd_reg(2'h1, 32'(nrec));
		rd_reg(2'h3, 32'h0000_0000);
		rd_reg(2'h2, 32'h0000_0005);
		// Three branches on consecutive cycles overrun the single slot.
		@(posedge clk);
		br_valid <= 1'b1;
		src <= 32'h0300_0000;
		for (int k = 0; k < 10; k++) begin
			@(posedge clk);
			if (drop === 1'b1) n++;
			if (k == 2) br_valid <= 1'b0;
			src <= src + 32'h0000_0010;
		end
		chk(32'(n > 0), 32'h0000_0001);
		repeat (600) @(posedge clk);
		rt <= 1'b0;
		br(BR_NORMAL, 32'h0300_1000, 32'h0000_0600, 4'h0);
		@(posedge clk);
		#1;
		chk(32'(stall), 32'h0000_0001);
		exp_rec(K_BRANCH, 32'h0300_1000, 32'h0000_0600, 1'b1);
		chk(32'(stall), 32'h0000_0000);
		results();
	end
endmodule

/* trace_device.sv */
// Purpose: On-chip trace capture, history and trace port serialiser.
// Assumes: Core inputs are synchronous to i_clock.
// Notes: A record is a header nibble, address nibbles, then extra nibbles for branch and software records only.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "trace_regs.svh"
module trace_device
	import trace_pkg::*;
#(
	parameter int DIV_HALF   = `TR_DIV_HALF,
	parameter int HIST_DEPTH = `TR_HIST_DEPTH
) (
	input  wire logic             i_clock,        // System clock.
	input  wire logic             i_rst_n,        // Async reset, low.
	input  wire logic             i_ubc_user,     // Break unit user-owned.
	input  wire logic             i_realtime,     // Realtime trace mode.
	input  wire logic             i_br_trace_en,  // Branch port trace on.
	input  wire logic [2:0]       i_br_type_en,   // Per branch kind enable.
	input  wire logic             i_hist_en,      // Internal history on.
	input  wire logic             i_sw_en,        // Software trace on.
	input  wire logic [1:0]       i_win_en,       // Window channel enables.
	input  wire rw_sel_e          i_win_rw [2],   // Cycle type per channel.
	input  wire bus_sel_e         i_win_bus [2],  // Watched bus per channel.
	input  wire logic [31:0]      i_win_start [2], // Range start, inclusive.
	input  wire logic [31:0]      i_win_end [2],  // Range end, inclusive.
	input  wire logic             i_br_valid,     // Branch taken pulse.
	input  wire br_kind_e         i_br_kind,      // Branch kind.
	input  wire logic [31:0]      i_br_src,       // Branch source.
	input  wire logic [31:0]      i_br_dst,       // Branch destination.
	input  wire logic [31:0]      i_br_next_pc,   // Address after source.
	input  wire logic             i_br_exc_done,  // Completion exception.
	input  wire logic             i_br_cond,      // Conditional branch.
	input  wire logic             i_br_zero_disp, // Displacement is zero.
	input  wire logic             i_br_reset,     // Branch caused by reset.
	input  wire logic [3:0]       i_acc_valid,    // Access per bus L,X,Y,I.
	input  wire logic [3:0][31:0] i_acc_addr,     // Access address per bus.
	input  wire logic [3:0]       i_acc_wr,       // Access is a write.
	input  wire logic [3:0]       i_acc_hit,      // Cache hit.
	input  wire logic [3:0]       i_acc_dma,      // Cycle from DMA.
	input  wire logic             i_sw_valid,     // Marker instr pulse.
	input  wire logic [31:0]      i_sw_pc,        // Marker instr PC.
	input  wire logic [31:0]      i_sw_reg,       // Marker register value.
	input  wire logic [2:0]       i_hist_idx,     // History index, 0 newest.
	output logic [31:0]           o_hist_src,     // History source.
	output logic [31:0]           o_hist_dst,     // History destination.
	output logic                  o_stall,        // Core must hold events.
	output logic                  o_drop,         // Event lost pulse.
	trace_link_if.dev             link            // Trace output port.
);
	localparam int PW = $clog2(HIST_DEPTH);
	localparam int DW = $clog2(DIV_HALF + 1);
	localparam int LINK_HZ = `TR_CLK_HZ / (2 * DIV_HALF);
	initial begin
		if (LINK_HZ > `TR_LINK_MAX_HZ || DIV_HALF < 2) begin
			$error("trace port clock divider out of range");
		end
	end

	typedef enum logic [1:0] {S_IDLE = 2'b00, S_ADDR = 2'b01,
		S_EXTRA = 2'b11, S_END = 2'b10} ser_e;

	logic [3:0]       req;
	logic [31:0]      req_a [4];
	logic [31:0]      req_x [4];
	logic [1:0]       win_hit;
	logic [31:0]      win_addr [2];
	logic             br_take;
	logic [31:0]      br_src;
	logic [3:0]       slot_v;
	logic [31:0]      slot_a [4];
	logic [31:0]      slot_x [4];
	logic [31:0]      ref_a [4];
	logic [3:0]       ref_v;
	logic [31:0]      hist_src [HIST_DEPTH];
	logic [31:0]      hist_dst [HIST_DEPTH];
	logic [PW-1:0]    hist_ptr;
	logic [DW-1:0]    div_cnt;
	logic             fall;
	logic             take;
	kind_e            sel;
	size_e            next_size;
	ser_e             state;
	logic [3:0]       nib_left;
	logic [31:0]      sh_a;
	logic [31:0]      sh_x;
	logic             has_x;

	assign br_take = i_br_valid && !i_ubc_user
		&& !(i_br_cond && i_br_zero_disp)
		&& !(i_br_reset && i_br_dst == `TR_RESET_VEC);
	assign br_src = i_br_exc_done ? i_br_next_pc : i_br_src;

	assign req[K_BRANCH] = br_take && i_br_trace_en && i_br_type_en[i_br_kind];
	assign req_a[K_BRANCH] = br_src;
	assign req_x[K_BRANCH] = i_br_dst;
	assign req[K_SOFT] = i_sw_valid && i_sw_en && !i_ubc_user;
	assign req_a[K_SOFT] = i_sw_pc;
	assign req_x[K_SOFT] = i_sw_reg;

	for (genvar c = 0; c < 2; c++) begin : g_win
		logic cyc_ok;
		logic rw_ok;
		bus_sel_e b;
		assign b = i_win_bus[c];
		// system bus masks the top nibble
		assign win_addr[c] = (b == BUS_I) ?
			(i_acc_addr[b] & `TR_IBUS_MASK) : i_acc_addr[b];
		always_comb begin
			case (b)
				BUS_L:   cyc_ok = i_acc_valid[b] && !i_acc_dma[b];
				BUS_I:   cyc_ok = i_acc_valid[b] && !i_acc_hit[b];
				default: cyc_ok = i_acc_valid[b];
			endcase
			case (i_win_rw[c])
				RW_READ:  rw_ok = !i_acc_wr[b];
				RW_WRITE: rw_ok = i_acc_wr[b];
				default:  rw_ok = 1'b1;
			endcase
		end
		assign win_hit[c] = i_win_en[c] && !i_ubc_user && cyc_ok && rw_ok
			&& win_addr[c] >= i_win_start[c] && win_addr[c] <= i_win_end[c];
		// channel B serves whichever bus i_win_bus[1] selects
		assign req[c + 1] = win_hit[c];
		assign req_a[c + 1] = win_addr[c];
		assign req_x[c + 1] = '0;
	end

	// One pending slot per stream lets both channels hold a record each.
	for (genvar k = 0; k < 4; k++) begin : g_slot
		logic freed;
		assign freed = take && sel == kind_e'(k);
		always_ff @(posedge i_clock or negedge i_rst_n) begin
			if (!i_rst_n) begin
				slot_v[k] <= 1'b0;
				slot_a[k] <= '0;
				slot_x[k] <= '0;
			end else if (req[k] && (!slot_v[k] || freed)) begin
				slot_v[k] <= 1'b1;
				slot_a[k] <= req_a[k];
				slot_x[k] <= req_x[k];
			end else if (freed) begin
				slot_v[k] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drop <= 1'b0;
			o_stall <= 1'b0;
		end else begin
			o_drop <= i_realtime && |(req & slot_v);
			o_stall <= !i_realtime && |slot_v;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hist_ptr <= '0;
		end else if (br_take && i_hist_en) begin
			hist_ptr <= PW'(hist_ptr + 1'b1);
		end
	end
	always_ff @(posedge i_clock) begin
		if (br_take && i_hist_en) begin
			hist_src[hist_ptr] <= br_src;
			hist_dst[hist_ptr] <= i_br_dst;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hist_src <= '0;
			o_hist_dst <= '0;
		end else begin
			o_hist_src <= hist_src[PW'(hist_ptr - 1'b1 - i_hist_idx)];
			o_hist_dst <= hist_dst[PW'(hist_ptr - 1'b1 - i_hist_idx)];
		end
	end

	// Port clock divider; the port clock is a register, never gated.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_cnt <= '0;
			link.trace_port_clock <= 1'b0;
		end else if (div_cnt == DW'(DIV_HALF - 1)) begin
			div_cnt <= '0;
			link.trace_port_clock <= !link.trace_port_clock;
		end else begin
			div_cnt <= DW'(div_cnt + 1'b1);
		end
	end
	assign fall = div_cnt == DW'(DIV_HALF - 1) && link.trace_port_clock;

	always_comb begin
		sel = K_BRANCH;
		if (slot_v[K_SOFT]) sel = K_SOFT;
		else if (slot_v[K_BRANCH]) sel = K_BRANCH;
		else if (slot_v[K_WIN_A]) sel = K_WIN_A;
		else if (slot_v[K_WIN_B]) sel = K_WIN_B;
	end
	assign take = fall && state == S_IDLE && |slot_v;

	// shortest delta whose upper bits match
	always_comb begin
		if (!ref_v[sel] || sel == K_SOFT) next_size = SZ_32;
		else if (slot_a[sel][31:4] == ref_a[sel][31:4]) next_size = SZ_4;
		else if (slot_a[sel][31:8] == ref_a[sel][31:8]) next_size = SZ_8;
		else if (slot_a[sel][31:16] == ref_a[sel][31:16]) next_size = SZ_16;
		else next_size = SZ_32;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_v <= '0;
			for (int i = 0; i < 4; i++) ref_a[i] <= '0;
		end else if (take) begin
			ref_v[sel] <= 1'b1;
			ref_a[sel] <= slot_a[sel];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= S_IDLE;
			nib_left <= '0;
			sh_a <= '0;
			sh_x <= '0;
			has_x <= 1'b0;
			link.trace_output_port <= '0;
			link.trace_sync <= 1'b0;
		end else if (fall) begin
			case (state)
				S_IDLE: begin
					if (|slot_v) begin
						link.trace_output_port <= {sel, next_size};
						link.trace_sync <= 1'b1;
						sh_a <= slot_a[sel];
						sh_x <= slot_x[sel];
						has_x <= sel == K_BRANCH || sel == K_SOFT;
						nib_left <= nib_count(next_size);
						state <= S_ADDR;
					end
				end
				S_ADDR: begin
					link.trace_output_port <= sh_a[3:0];
					sh_a <= sh_a >> 4;
					nib_left <= 4'(nib_left - 1'b1);
					if (nib_left == 4'h1) begin
						nib_left <= `TR_EXTRA_NIB;
						state <= has_x ? S_EXTRA : S_END;
					end
				end
				S_EXTRA: begin
					link.trace_output_port <= sh_x[3:0];
					sh_x <= sh_x >> 4;
					nib_left <= 4'(nib_left - 1'b1);
					if (nib_left == 4'h1) state <= S_END;
				end
				S_END: begin
					link.trace_output_port <= '0;
					link.trace_sync <= 1'b0;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

/* trace_emulator.sv */
// Purpose: Emulator pod end: samples the trace port, rebuilds records.
// Assumes: Port clock half period spans at least two i_clock cycles.
// Notes: Records appear on a one-cycle strobe and in status registers.
`timescale 1ns/10ps
`include "trace_regs.svh"
module trace_emulator
	import trace_pkg::*;
(
	input  wire logic        i_clock,     // System clock.
	input  wire logic        i_rst_n,     // Async reset, low.
	input  wire logic [1:0]  i_addr,      // Register address.
	input  wire logic [31:0] i_wdata,     // Register write data.
	input  wire logic        i_wr,        // Write strobe.
	input  wire logic        i_rd,        // Read strobe.
	output logic [31:0]      o_rdata,     // Read data, next cycle.
	output logic             o_rec_valid, // Record strobe.
	output kind_e            o_rec_kind,  // Record stream.
	output logic [31:0]      o_rec_addr,  // Full address or delta.
	output logic [31:0]      o_rec_extra, // Destination or register.
	output logic             o_rec_full,  // Address is complete.
	trace_link_if.emu        link         // Trace output port.
);
	typedef enum logic [1:0] {E_IDLE = 2'b00, E_ADDR = 2'b01,
		E_EXTRA = 2'b11, E_DONE = 2'b10} emu_e;

	logic [5:0]  sy1;
	logic [5:0]  sy2;
	logic        clk_d;
	logic        rise;
	logic        s_sync;
	logic [3:0]  s_data;
	emu_e        state;
	kind_e       kind;
	size_e       size;
	logic [3:0]  nib;
	logic [3:0]  nib_left;
	logic [31:0] acc_a;
	logic [31:0] acc_x;
	logic [31:0] ref_a [4];
	logic [3:0]  ref_v;
	logic [31:0] rebuilt;
	logic        ref_clr;
	logic [31:0] rec_count;
	logic [31:0] err_count;

	// only a bounded port clock can be sampled here
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sy1 <= '0;
			sy2 <= '0;
			clk_d <= 1'b0;
		end else begin
			sy1 <= {link.trace_port_clock, link.trace_sync,
				link.trace_output_port};
			sy2 <= sy1;
			clk_d <= sy2[5];
		end
	end
	assign rise = sy2[5] && !clk_d;
	assign s_sync = sy2[4];
	assign s_data = sy2[3:0];
	assign ref_clr = i_wr && i_addr == `TR_REG_CTRL && i_wdata[0];
	assign rebuilt = (ref_a[kind] & ~size_mask(size)) | acc_a;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= E_IDLE;
			kind <= K_BRANCH;
			size <= SZ_32;
			nib <= '0;
			nib_left <= '0;
			acc_a <= '0;
			acc_x <= '0;
			err_count <= '0;
		end else begin
			case (state)
				E_IDLE: begin
					if (rise && s_sync) begin
						kind <= kind_e'(s_data[3:2]);
						size <= size_e'(s_data[1:0]);
						nib_left <= nib_count(size_e'(s_data[1:0]));
						nib <= '0;
						acc_a <= '0;
						acc_x <= '0;
						state <= E_ADDR;
					end
				end
				E_ADDR, E_EXTRA: begin
					if (rise && !s_sync) begin
						err_count <= 32'(err_count + 1'b1);
						state <= E_IDLE;
					end else if (rise) begin
						if (state == E_ADDR) acc_a[nib*4 +: 4] <= s_data;
						else acc_x[nib*4 +: 4] <= s_data;
						nib <= 4'(nib + 1'b1);
						nib_left <= 4'(nib_left - 1'b1);
						if (nib_left == 4'h1) begin
							nib <= '0;
							nib_left <= `TR_EXTRA_NIB;
							if (state == E_ADDR && (kind == K_BRANCH
								|| kind == K_SOFT)) begin
								state <= E_EXTRA;
							end else begin
								state <= E_DONE;
							end
						end
					end
				end
				E_DONE: state <= E_IDLE;
				default: state <= E_IDLE;
			endcase
		end
	end

	// rebuild from reference, else report the delta
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rec_valid <= 1'b0;
			o_rec_kind <= K_BRANCH;
			o_rec_addr <= '0;
			o_rec_extra <= '0;
			o_rec_full <= 1'b0;
			ref_v <= '0;
			rec_count <= '0;
			for (int i = 0; i < 4; i++) ref_a[i] <= '0;
		end else begin
			o_rec_valid <= state == E_DONE;
			if (ref_clr) ref_v <= '0;
			if (state == E_DONE) begin
				o_rec_kind <= kind;
				o_rec_extra <= acc_x;
				rec_count <= 32'(rec_count + 1'b1);
				if (size == SZ_32 || ref_v[kind]) begin
					o_rec_addr <= (size == SZ_32) ? acc_a : rebuilt;
					o_rec_full <= 1'b1;
					ref_a[kind] <= (size == SZ_32) ? acc_a : rebuilt;
					// A record setting a reference wins over a clear.
					ref_v[kind] <= 1'b1;
				end else begin
					o_rec_addr <= acc_a;
					o_rec_full <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				`TR_REG_COUNT: o_rdata <= rec_count;
				`TR_REG_LAST:  o_rdata <= o_rec_addr;
				`TR_REG_ERR:   o_rdata <= err_count;
				default:       o_rdata <= {28'h000_0000, ref_v};
			endcase
		end else begin
			o_rdata <= '0;
		end
	end
endmodule

/* trace_link_checker.sv */
// Purpose: Wire checks of the trace output port between both ends.
// Assumes: The port clock runs free, 2*DIV_HALF clocks a period.
// Notes: The header nibble is {kind, size}; size picks 1/2/4/8 nibbles.
`timescale 1ns/10ps
module trace_link_checker
	import trace_pkg::*;
#(
	parameter int DIV_HALF = 4
) (
	input wire logic       i_clock,           // System clock.
	input wire logic       i_rst_n,           // Async reset, low.
	input wire logic       trace_port_clock,  // Port clock.
	input wire logic [3:0] trace_output_port, // Port nibble.
	input wire logic       trace_sync         // Record framing.
);
	logic        clk_q;
	logic        sync_q;
	logic        ran;
	logic        sent;
	logic [3:0]  hdr;
	logic [3:0]  seen;
	int unsigned ccnt;
	int unsigned hcnt;
	int unsigned lcnt;
	logic        chg;
	logic        fall;
	logic        rise;

	assign chg  = trace_port_clock != clk_q;
	assign fall = clk_q && !trace_port_clock;
	assign rise = trace_sync && !sync_q;

	// Windows carry no extra word, so their records are eight nibbles short.
	function automatic int unsigned rec_len(input logic [3:0] h);
		int unsigned extra;
		extra = (h[3:2] == 2'(K_BRANCH) || h[3:2] == 2'(K_SOFT)) ? 8 : 0;
		return (1 + (1 << h[1:0]) + extra) * 2 * DIV_HALF;
	endfunction

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_q <= 1'b0;
			ran   <= 1'b0;
			ccnt  <= 0;
		end else begin
			clk_q <= trace_port_clock;
			ran   <= ran | chg;
			ccnt  <= chg ? 0 : ccnt + 1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_q <= 1'b0;
			sent   <= 1'b0;
			hcnt   <= 0;
			lcnt   <= 0;
			hdr    <= 4'h0;
			seen   <= 4'h0;
		end else begin
			sync_q <= trace_sync;
			sent   <= sent | (sync_q & ~trace_sync);
			hcnt   <= trace_sync ? hcnt + 1 : 0;
			lcnt   <= trace_sync ? 0 : lcnt + 1;
			if (rise) begin
				hdr <= trace_output_port;
				seen[trace_output_port[3:2]] <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	a_clk_period: assert property (chg && ran |-> ccnt == DIV_HALF - 1)
		else $error("port clock half period wrong");
	a_clk_running: assert property (!chg && ran |-> ccnt < DIV_HALF - 1)
		else $error("port clock held too long");
	a_data_on_fall: assert property ($changed(trace_output_port) |-> fall)
		else $error("port nibble changed off a falling port clock");
	a_sync_on_fall: assert property ($changed(trace_sync) |-> fall)
		else $error("framing changed off a falling port clock");
	a_rec_length: assert property (sync_q && !trace_sync |->
		hcnt == rec_len(hdr))
		else $error("record length does not match its header");
	a_rec_gap: assert property (rise && sent |-> lcnt >= 2 * DIV_HALF - 1)
		else $error("record started before the gap period ended");
	a_soft_full: assert property (rise &&
		trace_output_port[3:2] == 2'(K_SOFT) |->
		trace_output_port[1:0] == 2'(SZ_32))
		else $error("software record not sent as a full address");
	a_first_full: assert property (rise &&
		!seen[trace_output_port[3:2]] |->
		trace_output_port[1:0] == 2'(SZ_32))
		else $error("first record of a stream not a full address");
endmodule

/* trace_link_if.sv */
// Purpose: Trace output port between the device and the emulator pod.
// Assumes: The device makes the port clock; all lines are one-way.
// Notes: Data changes after the falling clock edge.
`timescale 1ns/10ps
interface trace_link_if;
	logic       trace_port_clock;
	logic [3:0] trace_output_port;
	logic       trace_sync;

	modport dev (
		output trace_port_clock,
		output trace_output_port,
		output trace_sync
	);
	modport emu (
		input  trace_port_clock,
		input  trace_output_port,
		input  trace_sync
	);
endinterface

/* trace_pkg.sv */
// Purpose: Types and helpers shared by both trace link ends.
// Assumes: trace_regs.svh provides the numeric constants.
// Notes: Size codes travel in the low two header bits.
`include "trace_regs.svh"
package trace_pkg;
	typedef enum logic [1:0] {K_BRANCH, K_WIN_A, K_WIN_B, K_SOFT} kind_e;
	typedef enum logic [1:0] {SZ_4, SZ_8, SZ_16, SZ_32} size_e;
	typedef enum logic [1:0] {BUS_L, BUS_X, BUS_Y, BUS_I} bus_sel_e;
	typedef enum logic [1:0] {RW_READ, RW_WRITE, RW_BOTH} rw_sel_e;
	typedef enum logic [1:0] {BR_NORMAL, BR_SUB, BR_EXC} br_kind_e;

	function automatic logic [3:0] nib_count(input size_e s);
		case (s)
			SZ_4:    nib_count = `TR_NIB_4;
			SZ_8:    nib_count = `TR_NIB_8;
			SZ_16:   nib_count = `TR_NIB_16;
			default: nib_count = `TR_NIB_32;
		endcase
	endfunction

	function automatic logic [31:0] size_mask(input size_e s);
		case (s)
			SZ_4:    size_mask = `TR_MASK_4;
			SZ_8:    size_mask = `TR_MASK_8;
			SZ_16:   size_mask = `TR_MASK_16;
			default: size_mask = `TR_MASK_32;
		endcase
	endfunction
endpackage

/* trace_regs.svh */
// Purpose: Shared constants of the trace capture link and its two ends.
// Assumes: Both ends include this file; the guard keeps one copy.
// Notes: Functional notes follow as one line for each item.
// Functional notes
// - Two separately enabled address-range window channels.
// - Each channel qualifies read, write or both.
// - Local bus watch includes cache-hit CPU cycles.
// - System bus: CPU and DMA, 28 address bits.
// - Configurer puts first DSP bus on A.
// - Marker instruction emits PC and one register.
// - Branch source sent as 4/8/16/32-bit delta.
// - Window addresses use the same delta compression.
// - Emulator rebuilds full addresses, else reports delta.
// - Completion exception records the following address.
// - History keeps the last eight branch pairs.
// - Skip zero-displacement conditionals and reset branch.
// - No trace while break unit is user-owned.
// - Non-realtime mode stalls; writes may repeat.
// - Realtime mode drops events while busy.
// - Test clock must stay below peripheral clock.
// - Trace port clock at most 50 MHz.
`ifndef TRACE_REGS_SVH
`define TRACE_REGS_SVH
`define TR_CLK_HZ      25000000
`define TR_LINK_MAX_HZ 50000000
`define TR_DIV_HALF    4
`define TR_HIST_DEPTH  8
`define TR_RESET_VEC   32'hA000_0000
`define TR_IBUS_MASK   32'h0FFF_FFFF
`define TR_MASK_4      32'h0000_000F
`define TR_MASK_8      32'h0000_00FF
`define TR_MASK_16     32'h0000_FFFF
`define TR_MASK_32     32'hFFFF_FFFF
`define TR_NIB_4       4'h1
`define TR_NIB_8       4'h2
`define TR_NIB_16      4'h4
`define TR_NIB_32      4'h8
`define TR_EXTRA_NIB   4'h8
`define TR_REG_CTRL    2'h0
`define TR_REG_COUNT   2'h1
`define TR_REG_LAST    2'h2
`define TR_REG_ERR     2'h3
`endif
